// ### rtl/ebp_pkg.sv
package ebp_pkg;

    // Port geometry
    localparam int EBP_PORT_W = 8;
    localparam int EBP_PIN_SIX = 6;
    localparam int EBP_PIN_SEVEN = 7;

    // Register indices and their Avalon byte addresses (index times four)
    localparam int EBP_ADDR_W = 18;
    localparam logic [15:0] EBP_DIR_IDX = 16'hFFD4;
    localparam logic [15:0] EBP_DATA_IDX = 16'hFFD6;
    localparam logic [EBP_ADDR_W-1:0] EBP_DIR_ADDR = {EBP_DIR_IDX, 2'b00};
    localparam logic [EBP_ADDR_W-1:0] EBP_DATA_ADDR = {EBP_DATA_IDX, 2'b00};

    // Reset and read-back values
    localparam logic [7:0] EBP_DIR_RESET = 8'h00;
    localparam logic [7:0] EBP_DATA_RESET = 8'h00;
    localparam logic [7:0] EBP_DIR_READ = 8'hFF;
    localparam logic [31:0] EBP_UNMAPPED_READ = 32'h0000_0000;

    // Operating mode in which chip select 7 is not available on pin 6
    localparam logic [2:0] EBP_MODE_SINGLE_CHIP = 3'h7;

    // Synchroniser depth for pin inputs
    localparam int EBP_SYNC_STAGES = 3;

    // Bus answer state machine, one-hot
    typedef enum logic [1:0] {
        EBP_BUS_IDLE = 2'b01,
        EBP_BUS_ACK = 2'b10
    } ebp_bus_state_t;

    // DMA transfer-source bits of one channel, from its two control registers
    typedef struct packed {
        logic source_a_bit2;
        logic source_a_bit1;
        logic source_a_bit0;
        logic source_b_bit2;
        logic source_b_bit1;
    } ebp_dma_src_t;

    // Peripheral controls and outputs that steer the two upper pins
    typedef struct packed {
        logic pattern_enable_bit15;
        logic pattern_enable_bit14;
        logic pattern_output15;
        logic pattern_output14;
        logic converter_trigger_enable;
        logic chip_select7_enable;
        logic chip_select_seven_n;
        logic [2:0] op_mode;
        ebp_dma_src_t dma1_src;
        ebp_dma_src_t dma0_src;
    } ebp_periph_t;

    // Request-input lines delivered to other units (active low)
    typedef struct packed {
        logic dma1_request_in_n;
        logic dma0_request_in_n;
        logic converter_ext_trigger_n;
    } ebp_req_t;

endpackage

// ### rtl/ebp_sync.sv
`timescale 1ns/1ps

// Three-stage pin synchroniser; the output moves only once stages two and three agree
module ebp_sync
    import ebp_pkg::*;
#(
    parameter int WIDTH = EBP_PORT_W,
    parameter logic [WIDTH-1:0] INIT = '0
)
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] stable_out
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] mid_ff;
    logic [WIDTH-1:0] last_ff;
    logic [WIDTH-1:0] stable_ff;
    logic [WIDTH-1:0] nxt_stable;

    // Accept a new level per bit only when the two settled stages match
    always_comb
    begin
        nxt_stable = stable_ff;
        for (int i = 0; i < WIDTH; i++)
        begin
            if (mid_ff[i] == last_ff[i])
            begin
                nxt_stable[i] = last_ff[i];
            end
        end
    end

    // Shift chain and filtered level
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            meta_ff <= INIT;
            mid_ff <= INIT;
            last_ff <= INIT;
            stable_ff <= INIT;
        end
        else
        begin
            meta_ff <= async_in;
            mid_ff <= meta_ff;
            last_ff <= mid_ff;
            stable_ff <= nxt_stable;
        end
    end

    assign stable_out = stable_ff;

endmodule

// ### rtl/ebp_top.sv
`timescale 1ns/1ps

// Summary of operation
// - Reset or hardware standby leaves every port pin configured as an input.
// - Each direction bit sets its pin: one is output, zero is input.
// - Direction register is write-only; reading it returns all ones.
// - Direction register clears to zero on reset and in hardware standby.
// - Software standby keeps direction, and output pins keep driving their state.
// - Output data clears on reset and hardware standby, holds through software standby.
// - Eight-bit output data register is readable and writable, one bit per pin.
// - Port read gives stored data for output pins, pin level for input pins.
// - Pin 7: input, port output, or pattern output 15 by direction and enable.
// - Pin 7 feeds DMA channel 1 request under the source-field decode.
// - Pin 7 feeds the converter external trigger whenever trigger enable is one.
// - Pin 6: chip-select 7 enable wins; else like pin 7 with pattern 14.
// - Pin 6 feeds DMA channel 0 request under the same source decode.
// - Chip select 7 appears on pin 6 only in modes 0 to 6.
module ebp_top
    import ebp_pkg::*;
#(
    parameter int PORT_W = EBP_PORT_W
)
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [EBP_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic hw_standby,
    input wire logic sw_standby,
    input wire ebp_periph_t periph,
    input wire logic [PORT_W-1:0] pin_in,
    output logic [PORT_W-1:0] pin_out,
    output logic [PORT_W-1:0] pin_oe,
    output ebp_req_t req_out
);

    // DMA request routing decode for one channel
    function automatic logic dreq_routed(input ebp_dma_src_t s);
        logic a_both;
        logic b_both;
        a_both = s.source_a_bit2 & s.source_a_bit1;
        b_both = s.source_b_bit2 & s.source_b_bit1;
        if (!a_both)
        begin
            dreq_routed = b_both;
        end
        else
        begin
            dreq_routed = (!s.source_a_bit0 && s.source_b_bit2) || b_both;
        end
    endfunction

    // Synchronised pin levels and hardware standby
    logic [PORT_W-1:0] pin_lvl;
    logic hw_stby;
    logic [PORT_W:0] sync_in;
    logic [PORT_W:0] sync_out;

    // Register file state
    logic [PORT_W-1:0] dir_ff;
    logic [PORT_W-1:0] nxt_dir;
    logic [PORT_W-1:0] data_ff;
    logic [PORT_W-1:0] nxt_data;

    // Bus answer state
    ebp_bus_state_t state_ff;
    ebp_bus_state_t nxt_state;
    logic wait_ff;
    logic nxt_wait;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic bus_req;
    logic wr_commit;
    logic hit_dir;
    logic hit_data;
    logic [PORT_W-1:0] port_read;

    // Pin drive state
    logic [PORT_W-1:0] pin_out_ff;
    logic [PORT_W-1:0] nxt_pin_out;
    logic [PORT_W-1:0] pin_oe_ff;
    logic [PORT_W-1:0] nxt_pin_oe;

    // Request lines toward other units
    ebp_req_t req_ff;
    ebp_req_t nxt_req;
    logic cs7_active;

    // Pins and standby pass the three-stage filter together
    assign sync_in = {hw_standby, pin_in};

    ebp_sync #(
        .WIDTH(PORT_W + 1),
        .INIT('0)
    ) u_sync (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .async_in(sync_in),
        .stable_out(sync_out)
    );

    assign pin_lvl = sync_out[PORT_W-1:0];
    assign hw_stby = sync_out[PORT_W];

    // Address decode and port read mux
    always_comb
    begin
        bus_req = avs_read | avs_write;
        hit_dir = (avs_address == EBP_DIR_ADDR);
        hit_data = (avs_address == EBP_DATA_ADDR);
        wr_commit = avs_write && (state_ff == EBP_BUS_ACK);
        port_read = (dir_ff & data_ff) | (~dir_ff & pin_lvl);
    end

    // Bus answer: one wait cycle, then waitrequest low for exactly one cycle
    always_comb
    begin
        nxt_state = state_ff;
        nxt_rdata = rdata_ff;
        case (state_ff)
            EBP_BUS_IDLE:
            begin
                if (bus_req)
                begin
                    nxt_state = EBP_BUS_ACK;
                    if (hit_dir)
                    begin
                        nxt_rdata = {24'h00_0000, EBP_DIR_READ};
                    end
                    else if (hit_data)
                    begin
                        nxt_rdata = {24'h00_0000, port_read};
                    end
                    else
                    begin
                        nxt_rdata = EBP_UNMAPPED_READ;
                    end
                end
            end
            EBP_BUS_ACK:
            begin
                nxt_state = EBP_BUS_IDLE;
            end
            default:
            begin
                nxt_state = EBP_BUS_IDLE;
            end
        endcase
        nxt_wait = (nxt_state != EBP_BUS_ACK);
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            state_ff <= EBP_BUS_IDLE;
            wait_ff <= 1'b1;
            rdata_ff <= EBP_UNMAPPED_READ;
        end
        else
        begin
            state_ff <= nxt_state;
            wait_ff <= nxt_wait;
            rdata_ff <= nxt_rdata;
        end
    end

    // Direction and data registers; hardware standby clears, software standby leaves alone
    always_comb
    begin
        nxt_dir = dir_ff;
        nxt_data = data_ff;
        if (hw_stby)
        begin
            nxt_dir = EBP_DIR_RESET;
            nxt_data = EBP_DATA_RESET;
        end
        else if (wr_commit && hit_dir)
        begin
            nxt_dir = avs_writedata[PORT_W-1:0];
        end
        else if (wr_commit && hit_data)
        begin
            nxt_data = avs_writedata[PORT_W-1:0];
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            dir_ff <= EBP_DIR_RESET;
            data_ff <= EBP_DATA_RESET;
        end
        else
        begin
            dir_ff <= nxt_dir;
            data_ff <= nxt_data;
        end
    end

    // Chip select 7 is blocked in single-chip mode
    assign cs7_active = periph.chip_select7_enable && (periph.op_mode != EBP_MODE_SINGLE_CHIP);

    // Pin function mux; software standby freezes the drivers as they stand
    always_comb
    begin
        nxt_pin_out = pin_out_ff;
        nxt_pin_oe = pin_oe_ff;
        if (hw_stby)
        begin
            nxt_pin_out = '0;
            nxt_pin_oe = '0;
        end
        else if (!sw_standby)
        begin
            nxt_pin_oe = dir_ff;
            nxt_pin_out = data_ff;
            // Pin 7: pattern output 15 when enabled on an output pin
            if (dir_ff[EBP_PIN_SEVEN] && periph.pattern_enable_bit15)
            begin
                nxt_pin_out[EBP_PIN_SEVEN] = periph.pattern_output15;
            end
            // Pin 6: chip select 7 takes the pin regardless of direction
            if (cs7_active)
            begin
                nxt_pin_oe[EBP_PIN_SIX] = 1'b1;
                nxt_pin_out[EBP_PIN_SIX] = periph.chip_select_seven_n;
            end
            else if (dir_ff[EBP_PIN_SIX] && periph.pattern_enable_bit14)
            begin
                nxt_pin_out[EBP_PIN_SIX] = periph.pattern_output14;
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            pin_out_ff <= '0;
            pin_oe_ff <= '0;
        end
        else
        begin
            pin_out_ff <= nxt_pin_out;
            pin_oe_ff <= nxt_pin_oe;
        end
    end

    // Input functions of the upper pins; an unrouted request line rests high
    always_comb
    begin
        nxt_req.dma1_request_in_n = 1'b1;
        nxt_req.dma0_request_in_n = 1'b1;
        nxt_req.converter_ext_trigger_n = 1'b1;
        if (!dir_ff[EBP_PIN_SEVEN] && dreq_routed(periph.dma1_src))
        begin
            nxt_req.dma1_request_in_n = pin_lvl[EBP_PIN_SEVEN];
        end
        if (!dir_ff[EBP_PIN_SIX] && !cs7_active && dreq_routed(periph.dma0_src))
        begin
            nxt_req.dma0_request_in_n = pin_lvl[EBP_PIN_SIX];
        end
        if (periph.converter_trigger_enable)
        begin
            nxt_req.converter_ext_trigger_n = pin_lvl[EBP_PIN_SEVEN];
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            req_ff <= '1;
        end
        else
        begin
            req_ff <= nxt_req;
        end
    end

    // Outputs straight from flip-flops
    assign avs_readdata = rdata_ff;
    assign avs_waitrequest = wait_ff;
    assign pin_out = pin_out_ff;
    assign pin_oe = pin_oe_ff;
    assign req_out = req_ff;

endmodule

// ### verif/ebp_pins_model.sv
`timescale 1ns/1ps

// Board side of the port; a pin that nobody drives is pulled up
module ebp_pins_model (
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] ext_drv,
    input wire logic [7:0] ext_en,
    output logic [7:0] pin_in
);
    // Wire level: port driver first, then board driver, then pull-up
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            pin_in[i] = pin_oe[i] ? pin_out[i] : (ext_en[i] ? ext_drv[i] : 1'b1);
        end
    end
endmodule

// ### verif/ebp_top_sva.sv
`timescale 1ns/1ps

// Port-level checks on the bus answer and the pin steering
module ebp_top_sva
    import ebp_pkg::*;
#(
    parameter int PORT_W = EBP_PORT_W
)
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [EBP_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic hw_standby,
    input wire logic sw_standby,
    input wire ebp_periph_t periph,
    input wire logic [PORT_W-1:0] pin_in,
    input wire logic [PORT_W-1:0] pin_out,
    input wire logic [PORT_W-1:0] pin_oe,
    input wire ebp_req_t req_out
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    // Bus answers and register read-back
    a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer late");
    a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    a_dir_ones: assert property (!avs_waitrequest && avs_read && avs_address == EBP_DIR_ADDR
        |-> avs_readdata == 32'h0000_00FF)
        else $error("direction read not all ones");
    a_unmapped_zero: assert property (!avs_waitrequest && avs_read && avs_address != EBP_DIR_ADDR
        && avs_address != EBP_DATA_ADDR |-> avs_readdata == EBP_UNMAPPED_READ)
        else $error("unmapped read not zero");
    a_upper_zero: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
        else $error("read upper bits set");

    // Pin state after reset and in standby
    a_reset_input: assert property ($rose(resetn) |-> pin_oe == '0 && req_out == 3'b111)
        else $error("pins not inputs after reset");
    a_sw_hold: assert property (sw_standby && $past(sw_standby)
        |-> $stable(pin_oe) && $stable(pin_out))
        else $error("pins moved in software standby");

    // Peripheral outputs and the converter trigger input on the upper pins
    a_cs7_drive: assert property (periph.chip_select7_enable
        && periph.op_mode != EBP_MODE_SINGLE_CHIP && !sw_standby
        |=> pin_oe[6] && pin_out[6] == $past(periph.chip_select_seven_n))
        else $error("chip select not on pin 6");
    a_pat_seven: assert property (pin_oe[7] && $past(periph.pattern_enable_bit15)
        && !$past(sw_standby) |-> pin_out[7] == $past(periph.pattern_output15))
        else $error("pattern not on pin 7");
    a_trig_off: assert property ($past(!periph.converter_trigger_enable)
        |-> req_out.converter_ext_trigger_n)
        else $error("trigger routed while disabled");

    cover property (!avs_waitrequest && avs_write);
    cover property (sw_standby [*2]);
    cover property (!req_out.dma1_request_in_n);
endmodule

bind ebp_top ebp_top_sva #(.PORT_W(PORT_W)) ebp_top_sva_inst (.*);

// ### verif/testbench.sv
`timescale 1ns/1ps

module testbench
    import ebp_pkg::*;
;
    logic sys_clk, resetn, avs_read, avs_write, avs_waitrequest, hw_standby, sw_standby;
    logic [EBP_ADDR_W-1:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [7:0] pin_in, pin_out, pin_oe, ext_drv, ext_en;
    logic [5:0] tbl [5];
    ebp_periph_t periph;
    ebp_req_t req_out;
    int bad_count, n_compared, cyc;

    ebp_top ebp_top_inst (.sys_clk(sys_clk), .resetn(resetn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .hw_standby(hw_standby),
        .sw_standby(sw_standby), .periph(periph), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .req_out(req_out));
    ebp_pins_model ebp_pins_model_inst (.pin_out(pin_out), .pin_oe(pin_oe), .ext_drv(ext_drv),
        .ext_en(ext_en), .pin_in(pin_in));

    // Clock at 20 MHz
    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // Hang guard
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            bad_count++;
            end_sim();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // One Avalon transfer; request held until waitrequest is seen low at a rising edge, data taken there
    task automatic bus(input logic w, input logic [EBP_ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= {24'h0, d};
        do
            @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic rd(input logic [EBP_ADDR_W-1:0] a, input logic [31:0] e);
        bus(1'b0, a, 8'h00);
        chk(q, e);
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task end_sim;
        if (bad_count == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        {resetn, avs_read, avs_write, hw_standby, sw_standby} = '0;
        avs_address = '0;
        avs_writedata = '0;
        periph = '0;
        periph.chip_select_seven_n = 1'b1;
        ext_drv = 8'h3C;
        ext_en = 8'hCF;
        tbl = '{6'h07, 6'h04, 6'h35, 6'h3C, 6'h3F};
        wt(12);
        resetn <= 1'b1;
        rd(EBP_DIR_ADDR, 32'h0000_00FF);
        // All pins are inputs after reset, so a data read shows the board levels
        rd(EBP_DATA_ADDR, 32'h0000_003C);
        chk({24'h0, pin_oe}, 32'h0000_0000);
        chk({24'h0, pin_out}, 32'h0000_0000);
        chk({29'h0, req_out}, 32'h0000_0007);
        rd(18'h00010, EBP_UNMAPPED_READ);
        bus(1'b1, 18'h00010, 8'h77);
        rd(EBP_DATA_ADDR, 32'h0000_003C);
        chk({24'h0, pin_out}, 32'h0000_0000);
        // Mixed direction read
        bus(1'b1, EBP_DIR_ADDR, 8'h0F);
        bus(1'b1, EBP_DATA_ADDR, 8'hA5);
        wt(8);
        rd(EBP_DATA_ADDR, 32'h0000_0035);
        chk({24'h0, pin_oe}, 32'h0000_000F);
        chk({24'h0, pin_out & 8'h0F}, 32'h0000_0005);
        rd(EBP_DIR_ADDR, 32'h0000_00FF);
        // Pattern outputs on pins 7 and 6
        periph.pattern_enable_bit15 <= 1'b1;
        periph.pattern_enable_bit14 <= 1'b1;
        periph.pattern_output14 <= 1'b1;
        bus(1'b1, EBP_DIR_ADDR, 8'hFF);
        wt(3);
        chk({24'h0, pin_out}, 32'h0000_0065);
        rd(EBP_DATA_ADDR, 32'h0000_00A5);
        // Software standby freezes the pins
        sw_standby <= 1'b1;
        periph.pattern_output15 <= 1'b1;
        wt(4);
        chk({24'h0, pin_out}, 32'h0000_0065);
        chk({24'h0, pin_oe}, 32'h0000_00FF);
        sw_standby <= 1'b0;
        wt(3);
        chk({24'h0, pin_out}, 32'h0000_00E5);
        periph.pattern_enable_bit15 <= 1'b0;
        periph.pattern_enable_bit14 <= 1'b0;
        // Chip select 7, then mode 7
        bus(1'b1, EBP_DIR_ADDR, 8'h00);
        periph.chip_select7_enable <= 1'b1;
        periph.op_mode <= 3'h1;
        periph.chip_select_seven_n <= 1'b0;
        wt(3);
        chk({24'h0, pin_oe}, 32'h0000_0040);
        chk({31'h0, pin_out[6]}, 32'h0000_0000);
        periph.op_mode <= EBP_MODE_SINGLE_CHIP;
        wt(3);
        chk({24'h0, pin_oe}, 32'h0000_0000);
        // DMA request decode on both channels, pins 7 and 6 held low; chip select stays enabled in mode 7
        ext_drv <= 8'h3F;
        for (int i = 0; i < 5; i++)
        begin
            periph.dma1_src <= tbl[i][5:1];
            periph.dma0_src <= tbl[i][5:1];
            wt(8);
            // Bits 2 and 1 of the request struct are channel 1 and channel 0
            chk({30'h0, req_out[2:1]}, {30'h0, {2{!tbl[i][0]}}});
        end
        periph.chip_select7_enable <= 1'b0;
        periph.chip_select_seven_n <= 1'b1;
        // Converter trigger
        periph.converter_trigger_enable <= 1'b1;
        wt(8);
        chk({31'h0, req_out.converter_ext_trigger_n}, 32'h0000_0000);
        periph.converter_trigger_enable <= 1'b0;
        wt(3);
        chk({31'h0, req_out.converter_ext_trigger_n}, 32'h0000_0001);
        // Hardware standby clears both registers
        bus(1'b1, EBP_DIR_ADDR, 8'hF0);
        bus(1'b1, EBP_DATA_ADDR, 8'hFF);
        hw_standby <= 1'b1;
        wt(8);
        chk({24'h0, pin_oe}, 32'h0000_0000);
        bus(1'b1, EBP_DATA_ADDR, 8'h11);
        hw_standby <= 1'b0;
        wt(8);
        bus(1'b1, EBP_DIR_ADDR, 8'hFF);
        rd(EBP_DATA_ADDR, 32'h0000_0000);
        end_sim();
    end
endmodule
